// File: rtl/bdm_pkg.sv
// Package with address map, field positions and carrier types for the banked data memory.
package bdm_pkg;

  localparam int unsigned BDM_AW        = 9;
  localparam int unsigned BDM_DW        = 8;
  localparam int unsigned BDM_OFS_W     = 7;
  localparam int unsigned BDM_BANK_W    = 2;

  // Core register offsets within every bank.
  localparam logic [6:0] BDM_OFS_INDIRECT = 7'h00;
  localparam logic [6:0] BDM_OFS_PC_LOW   = 7'h02;
  localparam logic [6:0] BDM_OFS_STATUS   = 7'h03;
  localparam logic [6:0] BDM_OFS_POINTER  = 7'h04;
  localparam logic [6:0] BDM_OFS_PC_LATCH = 7'h0A;
  localparam logic [6:0] BDM_OFS_INT_CTRL = 7'h0B;

  // Start of general purpose space per bank group, and start of the common space shared with bank 0.
  localparam logic [6:0] BDM_GP_START_B0  = 7'h20;
  localparam logic [6:0] BDM_GP_START_BX  = 7'h20;
  localparam logic [6:0] BDM_COMMON_START = 7'h70;

  // Bank select field inside the core status register.
  localparam int unsigned BDM_STATUS_BSL  = 5;
  localparam int unsigned BDM_STATUS_BSH  = 6;

  localparam logic [7:0] BDM_STATUS_RST   = 8'h18;
  localparam logic [7:0] BDM_ZERO_BYTE    = 8'h00;

  // Quarter cycle phases of an instruction cycle.
  localparam logic [1:0] BDM_Q1 = 2'h0;
  localparam logic [1:0] BDM_Q2 = 2'h1;
  localparam logic [1:0] BDM_Q3 = 2'h2;
  localparam logic [1:0] BDM_Q4 = 2'h3;

  typedef struct packed {
    logic       indirect;
    logic [6:0] ofs;
    logic       wr_en;
    logic [7:0] wr_data;
  } bdm_req_s;

  typedef struct packed {
    logic [7:0] rd_data;
    logic       rd_valid;
  } bdm_rsp_s;

endpackage : bdm_pkg

// File: rtl/bdm_decode.sv
// Maps a bank and offset onto one physical storage location.
`timescale 1ns/1ps
module bdm_decode
  import bdm_pkg::*;
(
  input  wire logic [1:0] bank,
  input  wire logic [6:0] ofs,
  output logic      [8:0] phys_addr,
  output logic            is_core_mirror
);

  always_comb
  begin
    phys_addr      = {bank, ofs};
    is_core_mirror = 1'b0;
    // Core registers decode to the bank 0 copy from any bank.
    if (ofs == BDM_OFS_INDIRECT || ofs == BDM_OFS_PC_LOW || ofs == BDM_OFS_STATUS ||
        ofs == BDM_OFS_POINTER || ofs == BDM_OFS_PC_LATCH || ofs == BDM_OFS_INT_CTRL)
    begin
      phys_addr      = {2'h0, ofs};
      is_core_mirror = 1'b1;
    end
    else if (ofs >= BDM_COMMON_START && bank != 2'h0)
    begin
      phys_addr = {2'h0, ofs};
    end
  end

endmodule : bdm_decode

// File: rtl/bdm_top.sv
// Banked data memory with address decoding, core registers and quarter cycle timing.
`timescale 1ns/1ps
module bdm_top
  import bdm_pkg::*;
#(
  parameter int unsigned DEPTH = 512
)
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire bdm_pkg::bdm_req_s  req,
  output logic                    [1:0] q_phase,
  output bdm_pkg::bdm_rsp_s       rsp,
  output logic                    [7:0] status_out,
  output logic                    [7:0] pointer_out,
  output logic                    [1:0] bank_out
);
  import bdm_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic [8:0] addr;
    logic       null_ref;
  } bdm_state_s;

  bdm_state_s state_q;
  bdm_state_s state_d;

  // Shared storage for every location except core status and pointer, which live in flops.
  logic [7:0] mem_q [DEPTH];

  logic [1:0] bank;
  logic [6:0] eff_ofs;
  logic [8:0] phys_addr;
  logic       is_core;
  logic       mem_we;

  // An access goes through the pointer when asked for or when it names the indirect location.
  function automatic logic uses_pointer(input bdm_req_s r);
    return r.indirect || r.ofs == BDM_OFS_INDIRECT;
  endfunction : uses_pointer

  // Core status lives in flops, reached only through its bank 0 mirror address.
  function automatic logic hits_status(input logic [8:0] a);
    return a == {2'h0, BDM_OFS_STATUS};
  endfunction : hits_status

  // Indirect pointer lives in flops, reached only through its bank 0 mirror address.
  function automatic logic hits_pointer(input logic [8:0] a);
    return a == {2'h0, BDM_OFS_POINTER};
  endfunction : hits_pointer

  // Indirect access uses the pointer, with the high bank bit taken from status and the low bank bit from pointer bit 7.
  always_comb
  begin
    bank    = {state_q.status[BDM_STATUS_BSH], state_q.status[BDM_STATUS_BSL]};
    eff_ofs = req.ofs;
    if (uses_pointer(req))
    begin
      eff_ofs = state_q.pointer[6:0];
      bank    = {state_q.status[BDM_STATUS_BSH], state_q.pointer[7]};
    end
  end

  bdm_decode u_decode (
    .bank           (bank),
    .ofs            (eff_ofs),
    .phys_addr      (phys_addr),
    .is_core_mirror (is_core)
  );

  always_comb
  begin
    state_d          = state_q;
    state_d.phase    = state_q.phase + 2'h1;
    state_d.rd_valid = 1'b0;
    mem_we           = 1'b0;
    case (state_q.phase)
      BDM_Q1:
      begin
        state_d.addr     = phys_addr;
        // A pointer aimed at the indirect location itself is a null reference.
        state_d.null_ref = uses_pointer(req) && (eff_ofs == BDM_OFS_INDIRECT);
      end
      BDM_Q2:
      begin
        state_d.rd_valid = 1'b1;
        if (state_q.null_ref)
          state_d.rd_data = BDM_ZERO_BYTE;
        else if (hits_status(state_q.addr))
          state_d.rd_data = state_q.status;
        else if (hits_pointer(state_q.addr))
          state_d.rd_data = state_q.pointer;
        else
          state_d.rd_data = mem_q[state_q.addr];
      end
      BDM_Q3:
      begin
      end
      BDM_Q4:
      begin
        if (req.wr_en && !state_q.null_ref)
        begin
          if (hits_status(state_q.addr))
            state_d.status = {req.wr_data[7:5], state_q.status[4:3], req.wr_data[2:0]};
          else if (hits_pointer(state_q.addr))
            state_d.pointer = req.wr_data;
          else
            mem_we = 1'b1;
        end
      end
      default:
      begin
        state_d.phase = BDM_Q1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q.phase    <= BDM_Q1;
      state_q.status   <= BDM_STATUS_RST;
      state_q.pointer  <= BDM_ZERO_BYTE;
      state_q.rd_data  <= BDM_ZERO_BYTE;
      state_q.rd_valid <= 1'b0;
      state_q.addr     <= 9'h000;
      state_q.null_ref <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_q[state_q.addr] <= req.wr_data;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q_phase     <= BDM_Q1;
      rsp         <= '0;
      status_out  <= BDM_STATUS_RST;
      pointer_out <= BDM_ZERO_BYTE;
      bank_out    <= 2'h0;
    end
    else
    begin
      q_phase     <= state_d.phase;
      rsp         <= '{rd_data: state_d.rd_data, rd_valid: state_d.rd_valid};
      status_out  <= state_d.status;
      pointer_out <= state_d.pointer;
      bank_out    <= {state_d.status[BDM_STATUS_BSH], state_d.status[BDM_STATUS_BSL]};
    end
  end

  logic unused_core;
  assign unused_core = is_core;

endmodule : bdm_top

// File: bench/bdm_top_props.sv
// Checker for phase timing, core register updates and bank select of the top module.
`timescale 1ns/1ps
module bdm_top_props #(
  parameter int unsigned DEPTH = 512
)
(
  input wire logic              clk,
  input wire logic              reset,
  input wire bdm_pkg::bdm_req_s req,
  input wire logic [1:0]        q_phase,
  input wire bdm_pkg::bdm_rsp_s rsp,
  input wire logic [7:0]        status_out,
  input wire logic [7:0]        pointer_out,
  input wire logic [1:0]        bank_out
);
  import bdm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_PHASE_STEP: assert property (1 |=> q_phase == 2'($past(q_phase) + 2'h1))
    else $error("phase out of step");
  AST_VALID_Q3: assert property (rsp.rd_valid == (q_phase == BDM_Q3))
    else $error("read valid outside Q3");
  AST_DATA_HOLD: assert property (q_phase != BDM_Q3 |-> $stable(rsp.rd_data))
    else $error("read data moved outside Q3");
  AST_STATUS_Q4: assert property ($changed(status_out) |-> $past(q_phase) == BDM_Q4)
    else $error("status changed outside Q4");
  AST_POINTER_Q4: assert property ($changed(pointer_out) |-> $past(q_phase) == BDM_Q4)
    else $error("pointer changed outside Q4");
  AST_STATUS_WR: assert property (q_phase == BDM_Q4 && req.wr_en && !req.indirect
    && req.ofs == BDM_OFS_STATUS |=> status_out == (($past(req.wr_data) & 8'hE7) | 8'h18))
    else $error("status write lost");
  AST_POINTER_WR: assert property (q_phase == BDM_Q4 && req.wr_en && !req.indirect
    && req.ofs == BDM_OFS_POINTER |=> pointer_out == $past(req.wr_data))
    else $error("pointer write lost");
  AST_BANK: assert property (bank_out == status_out[6:5])
    else $error("bank differs from status");
endmodule : bdm_top_props
bind bdm_top bdm_top_props #(.DEPTH(DEPTH)) u_props (.clk(clk), .reset(reset), .req(req),
  .q_phase(q_phase), .rsp(rsp), .status_out(status_out), .pointer_out(pointer_out),
  .bank_out(bank_out));

// File: bench/bdm_cpu_model.sv
// Core model that issues one data memory access per instruction cycle.
`timescale 1ns/1ps
module bdm_cpu_model (
  input  wire logic              clk,
  input  wire logic [1:0]        q_phase,
  input  wire bdm_pkg::bdm_rsp_s rsp,
  output bdm_pkg::bdm_req_s      req
);
  import bdm_pkg::*;
  initial req = '0;
  // The request is held for the whole instruction cycle so the Q4 write sees it.
  task automatic access(input bdm_req_s r, output logic [7:0] rd);
    for (int n = 0; n < 8 && q_phase !== BDM_Q1; n++) @(posedge clk) #1;
    if (q_phase !== BDM_Q1)
    begin
      testbench.mismatches++;
      $display("[ERR] %0t no Q1 phase seen", $time);
    end
    req = r;
    repeat (2) @(posedge clk);
    #1 rd = rsp.rd_data;
    repeat (2) @(posedge clk);
    #1;
  endtask : access
endmodule : bdm_cpu_model

// File: bench/testbench.sv
// Testbench for the banked data memory with directed and random accesses.
`timescale 1ns/1ps
module testbench;
  import bdm_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] q_phase, bank_out;
  logic [7:0] status_out, pointer_out, rd;
  logic [7:0] st = 8'h18;
  logic [7:0] ptr = 8'h00;
  logic [7:0] m [int];
  bdm_req_s   req;
  bdm_rsp_s   rsp;
  int         mismatches = 0;
  int         checks = 0;
  always #25 clk = ~clk;
  bdm_top #(.DEPTH(512)) u_bdm_top (.clk(clk), .reset(reset), .req(req), .q_phase(q_phase),
    .rsp(rsp), .status_out(status_out), .pointer_out(pointer_out), .bank_out(bank_out));
  bdm_cpu_model cpu (.clk(clk), .q_phase(q_phase), .rsp(rsp), .req(req));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [8:0] phys(input logic ind, input logic [6:0] o);
    logic [8:0] a;
    a = (ind || o == BDM_OFS_INDIRECT) ? {st[6], ptr} : {st[6:5], o};
    if (a[6:4] == 3'h7 || a[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h0A, 7'h0B}) a[8:7] = 2'b00;
    return a;
  endfunction : phys
  task automatic op(input logic ind, input logic [6:0] o, input logic we, input logic [7:0] d);
    logic [8:0] a;
    logic [7:0] e;
    a = phys(ind, o);
    e = (a == 9'h000) ? 8'h00 : (a == 9'h003) ? st : (a == 9'h004) ? ptr
      : m.exists(a) ? m[a] : 8'hxx;
    cpu.access({ind, o, we, d}, rd);
    if (e !== 8'hxx) chk(rd, e, "read");
    if (we && a == 9'h003) st = (d & 8'hE7) | 8'h18;
    else if (we && a == 9'h004) ptr = d;
    else if (we && a != 9'h000) m[a] = d;
    chk(status_out, st, "status");
    chk({6'h00, bank_out}, {6'h00, st[6:5]}, "bank");
    chk(pointer_out, ptr, "pointer");
    chk({6'h00, q_phase}, {6'h00, BDM_Q1}, "phase");
  endtask : op
  initial
  begin
    #1000000 mismatches++;
    stop_test();
  end
  initial
  begin
    void'($urandom(57));
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    chk(status_out, 8'h18, "reset status");
    $display("test reset done");
    for (int k = 0; k < 2; k++)
      for (int b = 0; b < 4; b++)
      begin
        op(1'b0, BDM_OFS_STATUS, 1'b1, 8'(b << 5));
        op(1'b0, 7'h7F, k == 0, 8'(b));
        op(1'b0, 7'h20, k == 0, 8'(b + 8'h50));
        op(1'b0, BDM_OFS_PC_LATCH, k == 0, 8'(b + 8'h60));
      end
    $display("test banks done");
    op(1'b0, BDM_OFS_POINTER, 1'b1, 8'hA0);
    op(1'b1, 7'h00, 1'b0, 8'h00);
    op(1'b0, BDM_OFS_POINTER, 1'b1, 8'h00);
    op(1'b1, 7'h15, 1'b1, 8'hA5);
    op(1'b1, 7'h15, 1'b0, 8'h00);
    $display("test pointer done");
    repeat (300) op(1'($urandom), 7'($urandom), 1'($urandom), 8'($urandom));
    $display("test random done");
    stop_test();
  end
endmodule : testbench
